// ### rtl/mbx_pkg.sv
package mbx_pkg;
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;

    // execution control field positions
    localparam int CTRL_W = 9;
    localparam int BIT_RUN_EN = 0;
    localparam int BIT_HALTED = 1;
    localparam int BIT_PROC_GATE = 2;
    localparam int BIT_SINGLE = 3;
    localparam int BIT_HALT_COND = 4;
    localparam int BIT_FINISHED = 5;
    localparam int BIT_FIN_GATE = 6;
    localparam int BIT_MISS = 7;
    localparam int BIT_MISS_GATE = 8;
    localparam int STATE_LSB = 12;
    localparam int STATE_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

    // interrupt sources
    localparam int IRQ_W = 3;
    localparam int IRQ_MISS = 0;
    localparam int IRQ_FINISH = 1;
    localparam int IRQ_HALT = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    typedef enum logic [STATE_W-1:0] {
        MBX_ST_INITIAL = 2'b00,
        MBX_ST_RUN = 2'b01,
        MBX_ST_SUSPENDED = 2'b10
    } mbx_exec_state_t;
endpackage

// ### rtl/mbx_sync2.sv
`timescale 1ns/10ps
module mbx_sync2
    import mbx_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // level crossing
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    logic sync_q;

    // first stage feeds only the second
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// ### rtl/mbx_irq.sv
`timescale 1ns/10ps
module mbx_irq
    import mbx_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // events and software access
    input wire logic [IRQ_W-1:0] evt_i,
    input wire logic wr_stat_i,
    input wire logic wr_mask_i,
    input wire logic [IRQ_W-1:0] wdata_i,
    // state
    output logic [IRQ_W-1:0] stat_o,
    output logic [IRQ_W-1:0] mask_o,
    output logic irq_o
);
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    logic irq_q;
    logic [IRQ_W-1:0] stat_d;

    // write one to clear; a new event wins over the clear
    genvar i;
    generate
        for (i = 0; i < IRQ_W; i++)
        begin : g_stat
            assign stat_d[i] = evt_i[i] | (stat_q[i] & ~(wr_stat_i & wdata_i[i]));
        end
    endgenerate

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stat_q <= IRQ_RESET;
            mask_q <= IRQ_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            if (wr_mask_i)
            begin
                mask_q <= wdata_i;
            end
            irq_q <= |(stat_d & (wr_mask_i ? wdata_i : mask_q));
        end
    end

    assign stat_o = stat_q;
    assign mask_o = mask_q;
    assign irq_o = irq_q;
endmodule

// ### rtl/mbx_exec_ctrl.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Behaviour
// - The test-failed pin is low while the miss output gate is clear and follows the miss flag while it is set.
// - A failed data compare sets the miss flag, and only a software write clears it.
// - The test-ended pin is low while the finish output gate is clear and mirrors the finished flag otherwise.
// - The execution stop event sets the finished flag, which holds until software clears it.
// - In single pass mode a final-loop instruction clears run enable and sets the finished flag.
// - The proceed input is ignored unless its gate is set, and then it can resume or suspend.
// - A launch halted event sets the halted flag, which marks execution as suspended.
// - Any resume event not met by a launch halted event in the same cycle clears the halted flag so that execution may proceed.
// - Writing zero to the halted flag while suspended performs a resume event.
// - The program runs only while run enable is one and the halted flag is zero.
// - Writing one to run enable and halted while run enable is zero launches into the suspended state.
module mbx_exec_ctrl
    import mbx_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    // test engine events
    input wire logic cmp_fail_i,
    input wire logic stop_event_i,
    input wire logic loop_last_i,
    output logic exec_run_o,
    // external test controller pins
    input wire logic proceed_input_i,
    output logic miss_pin_o,
    output logic finish_pin_o,
    // interrupt
    output logic irq_o
);
    function automatic logic is_ofs(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        is_ofs = (a == o);
    endfunction

    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic miss_pin_q;
    logic finish_pin_q;
    logic exec_run_q;
    logic proceed_prev_q;
    logic proceed_sync;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_evt;
    mbx_exec_state_t exec_state;

    // address decode
    wire wr_ctrl = reg_wr_i & is_ofs(reg_addr_i, OFS_CTRL);
    wire wr_stat = reg_wr_i & is_ofs(reg_addr_i, OFS_IRQ_STAT);
    wire wr_mask = reg_wr_i & is_ofs(reg_addr_i, OFS_IRQ_MASK);
    wire rd_ctrl = is_ofs(reg_addr_i, OFS_CTRL);
    wire rd_stat = is_ofs(reg_addr_i, OFS_IRQ_STAT);
    wire rd_mask = is_ofs(reg_addr_i, OFS_IRQ_MASK);

    // pin is asynchronous to our clock
    mbx_sync2 u_proceed_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(proceed_input_i),
        .sync_o(proceed_sync)
    );

    wire run_en = ctrl_q[BIT_RUN_EN];
    wire halted = ctrl_q[BIT_HALTED];
    wire exec_now = run_en & ~halted;

    wire proceed_rise = proceed_sync & ~proceed_prev_q & ctrl_q[BIT_PROC_GATE];
    wire pin_resume = proceed_rise & halted;
    wire pin_suspend = proceed_rise & exec_now;

    wire launch_halt = wr_ctrl & ~run_en & reg_wdata_i[BIT_RUN_EN] & reg_wdata_i[BIT_HALTED];
    wire sw_resume = wr_ctrl & halted & ~reg_wdata_i[BIT_HALTED];
    wire resume_evt = sw_resume | pin_resume;
    wire halt_set = launch_halt | pin_suspend;

    wire once_end = exec_now & loop_last_i & ctrl_q[BIT_SINGLE];
    wire fin_set = stop_event_i | once_end;
    wire miss_set = cmp_fail_i;

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d = reg_wdata_i[CTRL_W-1:0];
            // a running program must not be suspended by a stray write
            if (run_en)
            begin
                ctrl_d[BIT_HALTED] = halted;
            end
        end
        if (resume_evt)
        begin
            ctrl_d[BIT_HALTED] = 1'b0;
        end
        if (halt_set)
        begin
            ctrl_d[BIT_HALTED] = 1'b1;
        end
        if (once_end)
        begin
            ctrl_d[BIT_RUN_EN] = 1'b0;
        end
        if (fin_set)
        begin
            ctrl_d[BIT_FINISHED] = 1'b1;
        end
        if (miss_set)
        begin
            ctrl_d[BIT_MISS] = 1'b1;
        end
    end

    always_comb
    begin
        case ({halted, run_en})
            2'b01: exec_state = MBX_ST_RUN;
            2'b11: exec_state = MBX_ST_SUSPENDED;
            2'b10: exec_state = MBX_ST_SUSPENDED;
            default: exec_state = MBX_ST_INITIAL;
        endcase
    end

    // read mux, unmapped reads as zero
    wire [DATA_W-1:0] rd_ctrl_word = {{(DATA_W-STATE_LSB-STATE_W){1'b0}}, exec_state,
        {(STATE_LSB-CTRL_W){1'b0}}, ctrl_q};
    wire [DATA_W-1:0] rd_stat_word = {{(DATA_W-IRQ_W){1'b0}}, irq_stat};
    wire [DATA_W-1:0] rd_mask_word = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
    assign rdata_d = !reg_rd_i ? 32'h0000_0000 :
        rd_ctrl ? rd_ctrl_word :
        rd_stat ? rd_stat_word :
        rd_mask ? rd_mask_word : 32'h0000_0000;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= CTRL_RESET;
            rdata_q <= 32'h0000_0000;
            proceed_prev_q <= 1'b0;
            miss_pin_q <= 1'b0;
            finish_pin_q <= 1'b0;
            exec_run_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            proceed_prev_q <= proceed_sync;
            miss_pin_q <= ctrl_d[BIT_MISS_GATE] & ctrl_d[BIT_MISS];
            finish_pin_q <= ctrl_d[BIT_FIN_GATE] & ctrl_d[BIT_FINISHED];
            exec_run_q <= ctrl_d[BIT_RUN_EN] & ~ctrl_d[BIT_HALTED];
        end
    end

    // events seen by software
    assign irq_evt[IRQ_MISS] = miss_set;
    assign irq_evt[IRQ_FINISH] = fin_set;
    assign irq_evt[IRQ_HALT] = halt_set;

    mbx_irq u_irq (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .evt_i(irq_evt),
        .wr_stat_i(wr_stat),
        .wr_mask_i(wr_mask),
        .wdata_i(reg_wdata_i[IRQ_W-1:0]),
        .stat_o(irq_stat),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    assign reg_rdata_o = rdata_q;
    assign miss_pin_o = miss_pin_q;
    assign finish_pin_o = finish_pin_q;
    assign exec_run_o = exec_run_q;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_miss_pin_low: assert property (!ctrl_q[BIT_MISS_GATE] |-> !miss_pin_o)
        else $error("miss pin high while gate clear");
    a_miss_pin_follow: assert property (cmp_fail_i |=> ctrl_q[BIT_MISS] && miss_pin_o == ctrl_q[BIT_MISS_GATE])
        else $error("miss pin does not follow flag");
    a_miss_flag_holds: assert property (ctrl_q[BIT_MISS] && !wr_ctrl |=> ctrl_q[BIT_MISS])
        else $error("miss flag lost without a write");
    a_fin_pin_mirror: assert property (stop_event_i && ctrl_q[BIT_FIN_GATE] && !wr_ctrl |=> finish_pin_o)
        else $error("finish pin does not mirror flag");
    a_fin_flag_set: assert property (stop_event_i |=> ctrl_q[BIT_FINISHED] [*1] ##0 $past(stop_event_i))
        else $error("finished flag not set");
    a_once_end: assert property (once_end |=> !ctrl_q[BIT_RUN_EN] && ctrl_q[BIT_FINISHED] && !exec_run_o)
        else $error("single pass end not taken");
    a_proceed_ignored: assert property (!ctrl_q[BIT_PROC_GATE] && !wr_ctrl |=> $stable(ctrl_q[BIT_HALTED]))
        else $error("halted moved while proceed gated off");
    a_launch_halt: assert property (launch_halt |=> halted && run_en && !exec_run_o)
        else $error("launch did not suspend");
    a_pin_suspend: assert property (pin_suspend |=> halted ##1 1'b1)
        else $error("proceed edge did not suspend");
    a_resume_clears: assert property (resume_evt |=> !halted)
        else $error("resume left halted set");
    a_sw_resume_run: assert property (sw_resume && reg_wdata_i[BIT_RUN_EN] && !once_end |=> exec_run_o)
        else $error("software resume did not run");
    a_run_only_enabled: assert property (exec_run_o |-> run_en && !halted)
        else $error("running while disabled or halted");
    a_halt_cond_rw: assert property (wr_ctrl |=> ctrl_q[BIT_HALT_COND] == $past(reg_wdata_i[BIT_HALT_COND]))
        else $error("halt condition bit not stored");
    a_read_one_cycle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");

    c_launch_resume: cover property (launch_halt ##[1:50] sw_resume);
    c_once_end: cover property (once_end ##1 finish_pin_o);
    c_pin_resume: cover property (pin_resume);
    c_irq: cover property (irq_o && miss_pin_o);
endmodule

// ### testbench/mbx_test_ctrl.sv
`timescale 1ns/10ps
module mbx_test_ctrl
(
    // clock and command
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic [2:0] hold_i,
    // continue pin
    output logic proceed_o
);
    logic [2:0] cnt_q = 3'h0;
    initial proceed_o = 1'b0;
    // pin high for hold_i cycles after go, driven at the edge; the block still treats it as foreign
    always @(posedge clock_i)
    begin
        if (go_i)
        begin
            cnt_q <= hold_i;
            proceed_o <= 1'b1;
        end
        else if (cnt_q > 3'h1)
        begin
            cnt_q <= cnt_q - 3'h1;
        end
        else
        begin
            cnt_q <= 3'h0;
            proceed_o <= 1'b0;
        end
    end
endmodule

// ### testbench/tb_mbist_exec_control_bits.sv
`timescale 1ns/10ps
module tb_mbist_exec_control_bits
    import mbx_pkg::*;
();
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic wr = 0, rd = 0, cmp = 0, stp = 0, last = 0, go = 0, rd_d1 = 0;
    logic pin, miss, fin, run, irq;
    logic [2:0] hold = 3'h2;
    logic [DATA_W-1:0] exp_q[$];
    int fail_count = 0;
    int comparisons = 0;
    int k;

    always #50 clock_i = ~clock_i;

    mbx_exec_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cmp_fail_i(cmp), .stop_event_i(stp),
        .loop_last_i(last), .exec_run_o(run), .proceed_input_i(pin), .miss_pin_o(miss),
        .finish_pin_o(fin), .irq_o(irq));
    mbx_test_ctrl tc_u (.clock_i(clock_i), .go_i(go), .hold_i(hold), .proceed_o(pin));

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
            fail_count++;
        end
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clock_i) rd_d1 <= rd;
    always @(negedge clock_i)
        if (rd_d1)
            check(rdata, exp_q.pop_front(), "read data");

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(posedge clock_i);
    endtask

    // pins packed as miss, finish, run, irq
    // returns on a rising edge so the next bus call starts right after it
    task automatic pins(input logic [3:0] e, input string m);
        @(negedge clock_i);
        check({28'h0, miss, fin, run, irq}, {28'h0, e}, m);
        @(posedge clock_i);
    endtask

    task automatic pulse(input int s);
        if (s == 0)
            cmp <= 1'b1;
        else if (s == 1)
            stp <= 1'b1;
        else
            last <= 1'b1;
        @(posedge clock_i);
        cmp <= 1'b0;
        stp <= 1'b0;
        last <= 1'b0;
        @(posedge clock_i);
    endtask

    // far side raises the continue pin for a random length
    task automatic kick();
        go <= 1'b1;
        hold <= 3'($urandom_range(5, 2));
        @(posedge clock_i);
        go <= 1'b0;
        repeat (12) @(posedge clock_i);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'hc631f7c6));
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd_reg(OFS_CTRL, 32'h0);
        rd_reg(OFS_IRQ_MASK, 32'h0);
        addr <= {2'b11, 2'($urandom)};
        @(posedge clock_i);
        wr_reg(addr, $urandom);
        rd_reg(addr, 32'h0);
        wr_reg(OFS_CTRL, 32'h10);
        rd_reg(OFS_CTRL, 32'h10);
        wr_reg(OFS_CTRL, 32'h0);
        $display("test reset done");
        for (k = 0; k < 2; k++)
        begin
            pulse(k);
            repeat ($urandom_range(4, 1)) @(posedge clock_i);
            pins(4'h0, "gated pin");
            rd_reg(OFS_CTRL, k ? 32'h20 : 32'h80);
            wr_reg(OFS_CTRL, k ? 32'h60 : 32'h180);
            pins(k ? 4'h4 : 4'h8, "pin follows flag");
            wr_reg(OFS_CTRL, k ? 32'h40 : 32'h100);
            pins(4'h0, "cleared flag");
            wr_reg(OFS_CTRL, 32'h0);
        end
        $display("test flags done");
        rd_reg(OFS_IRQ_STAT, 32'h3);
        wr_reg(OFS_IRQ_MASK, 32'h2);
        pins(4'h1, "irq raised");
        wr_reg(OFS_IRQ_STAT, 32'h2);
        pins(4'h0, "irq cleared");
        rd_reg(OFS_IRQ_STAT, 32'h1);
        wr_reg(OFS_IRQ_MASK, 32'h0);
        wr_reg(OFS_IRQ_STAT, 32'h7);
        $display("test irq done");
        wr_reg(OFS_CTRL, 32'h3);
        pins(4'h0, "launch halted");
        rd_reg(OFS_CTRL, 32'h2003);
        rd_reg(OFS_IRQ_STAT, 32'h4);
        wr_reg(OFS_CTRL, 32'h1);
        pins(4'h2, "software resume");
        rd_reg(OFS_CTRL, 32'h1001);
        wr_reg(OFS_CTRL, 32'h3);
        pins(4'h2, "halt write dropped");
        $display("test launch done");
        kick();
        pins(4'h2, "continue ignored");
        wr_reg(OFS_CTRL, 32'h5);
        kick();
        pins(4'h0, "continue suspends");
        kick();
        pins(4'h2, "continue resumes");
        $display("test continue done");
        wr_reg(OFS_CTRL, 32'h1);
        pulse(2);
        pins(4'h2, "last loop no single");
        wr_reg(OFS_CTRL, 32'h49);
        pulse(2);
        pins(4'h4, "single pass end");
        rd_reg(OFS_CTRL, 32'h68);
        // stop event while the finish gate is already open
        wr_reg(OFS_CTRL, 32'h40);
        pins(4'h0, "finished cleared");
        pulse(1);
        pins(4'h4, "stop with gate set");
        $display("test single pass done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        pins(4'h0, "second reset");
        rd_reg(OFS_CTRL, 32'h0);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
